// ===== fbs_ctrl.sv
// fbs_ctrl.sv: parameter-driven behaviour control of a fieldbus slave.
// assumes a single 50 MHz clock, an AXI4-Lite master that runs at most
// one write and one read at a time, and asynchronous rack pins.
//
// Operation
// - station address 2..125, switch equals configured
// - sync for our group holds outputs
// - freeze latches inputs, reports latched values
// - watchdog expiry enters safety state
// - watchdog off: no forced zero outputs
// - ident enable reports faulty slot
// - module-state enable reports module error
// - channel enable reports faulty channel
// - diagnostic enable off suppresses all diagnostics outside the extended variant
// - byte order touches analog values only
// - big-endian: high byte first
// - little-endian: low byte first
// - reset reaction: reset, await parameters
// - disable reaction: exchange, outputs forced zero
// - plain reaction: exchange continues unchanged
// - extended status bytes 0..2 fixed
// - extended variant: diagnostic address slot 0
// - extended variant: fixed extended interrupt mode
// - at most 244 bytes each direction
`include "fbs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module fbs_ctrl #(
	parameter int unsigned WD_CYCLES = `FBS_WD_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// rack side pins
	input  wire fbs_pkg::fbs_pins_t pins,
	output logic [15:0]      bp_out,
	output logic             output_disable,
	output logic             safety_state
);

	// *****************************************
	// input synchronisers
	// *****************************************
	fbs_pkg::fbs_pins_t pins_s1_reg;  // first stage, read by second only
	fbs_pkg::fbs_pins_t pins_reg;     // usable copy

	// two flops before any logic looks at rack pins
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pins_s1_reg <= '0;
			pins_reg    <= '0;
		end
		else
		begin
			pins_s1_reg <= pins;
			pins_reg    <= pins_s1_reg;
		end
	end

	// *****************************************
	// helpers
	// *****************************************
	// maps a byte address onto a register slot, 4'hF when unmapped
	function automatic logic [3:0] reg_slot(input logic [7:0] a);
		if (a == `FBS_OFS_STAGE)        reg_slot = 4'h0;
		else if (a == `FBS_OFS_CMD)     reg_slot = 4'h1;
		else if (a == `FBS_OFS_OUT)     reg_slot = 4'h2;
		else if (a == `FBS_OFS_IN)      reg_slot = 4'h3;
		else if (a == `FBS_OFS_STATUS)  reg_slot = 4'h4;
		else if (a == `FBS_OFS_DIAG)    reg_slot = 4'h5;
		else if (a == `FBS_OFS_EXTSTAT) reg_slot = 4'h6;
		else if (a == `FBS_OFS_LEN)     reg_slot = 4'h7;
		else if (a == `FBS_OFS_ACTIVE)  reg_slot = 4'h8;
		else                            reg_slot = 4'hF;
	endfunction

	// byte order for analog values; digital passes untouched
	function automatic logic [15:0] order(input logic [15:0] v,
		input logic analog, input logic little);
		if (analog && little)
			order = {v[7:0], v[15:8]};
		else
			order = v;
	endfunction

	// *****************************************
	// axi4-lite write channel
	// *****************************************
	logic       aw_hold_reg;   // address taken, waiting for data
	logic       w_hold_reg;    // data taken, waiting for address
	logic [7:0] waddr_reg;     // captured write address
	logic [31:0] wdata_reg;    // captured write data
	logic [3:0] wstrb_reg;     // captured byte enables
	logic       wr_fire;       // one-cycle register write strobe

	assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

	// address and data are taken independently, response follows both
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			aw_hold_reg   <= 1'b0;
			w_hold_reg    <= 1'b0;
			waddr_reg     <= 8'h00;
			wdata_reg     <= 32'h0000_0000;
			wstrb_reg     <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `FBS_RESP_OK;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_reg   <= 1'b1;
				waddr_reg     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_reg   <= 1'b1;
				wdata_reg    <= s_axi_wdata;
				wstrb_reg    <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire)
			begin
				// read-only and unmapped slots answer with an error
				aw_hold_reg  <= 1'b0;
				w_hold_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (reg_slot(waddr_reg) <= 4'h2) ?
					`FBS_RESP_OK : `FBS_RESP_ERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// decoded write pulses
	logic        wr_stage;
	logic        wr_cmd;
	logic        wr_out;
	logic [31:0] wmask;
	assign wr_stage = wr_fire && (reg_slot(waddr_reg) == 4'h0);
	assign wr_cmd   = wr_fire && (reg_slot(waddr_reg) == 4'h1);
	assign wr_out   = wr_fire && (reg_slot(waddr_reg) == 4'h2);
	assign wmask    = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
		{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

	// *****************************************
	// parameter staging and commit
	// *****************************************
	logic [31:0] stage_reg;             // telegram being assembled
	fbs_pkg::fbs_param_t prm_reg;       // settings in force
	logic        prm_valid_reg;         // a telegram has been accepted
	logic        cmd_commit;
	logic        cmd_sync;
	logic        cmd_unsync;
	logic        cmd_freeze;
	logic        cmd_unfreeze;
	logic        cmd_poll;
	logic        grp_hit;
	logic        soft_reset;            // module timeout reset reaction

	assign grp_hit      = |(wdata_reg[`FBS_C_GROUP +: 8] & prm_reg.group);
	assign cmd_commit   = wr_cmd && wstrb_reg[0] && wdata_reg[`FBS_C_COMMIT];
	assign cmd_sync     = wr_cmd && wdata_reg[`FBS_C_SYNC] && grp_hit;
	assign cmd_unsync   = wr_cmd && wdata_reg[`FBS_C_UNSYNC] && grp_hit;
	assign cmd_freeze   = wr_cmd && wdata_reg[`FBS_C_FREEZE] && grp_hit;
	assign cmd_unfreeze = wr_cmd && wdata_reg[`FBS_C_UNFRZ] && grp_hit;
	assign cmd_poll     = wr_cmd && wdata_reg[`FBS_C_POLL];

	// staging is byte-writable and never steers the logic directly
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			stage_reg <= `FBS_STAGE_RST;
		else if (wr_stage)
			stage_reg <= (stage_reg & ~wmask) | (wdata_reg & wmask);
	end

	// settings change only on a whole commit, else the old set stays
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prm_reg       <= fbs_pkg::fbs_param_t'(`FBS_STAGE_RST);
			prm_valid_reg <= 1'b0;
		end
		else if (cmd_commit)
		begin
			prm_reg       <= fbs_pkg::fbs_param_t'(stage_reg[23:0]);
			prm_valid_reg <= 1'b1;
		end
		else if (soft_reset)
			prm_valid_reg <= 1'b0;
	end

	// station address inside 2..125 and matching the switch
	logic addr_ok;
	assign addr_ok = (prm_reg.addr >= `FBS_ADDR_MIN) &&
		(prm_reg.addr <= `FBS_ADDR_MAX) &&
		(prm_reg.addr == pins_reg.addr_sw);

	// *****************************************
	// watchdog
	// *****************************************
	logic [31:0] wd_cnt_reg;   // cycles since the master last polled
	logic        wd_expired;
	assign wd_expired = (wd_cnt_reg >= WD_CYCLES);

	// restarts on each poll or commit, so a late first commit cannot trip it
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			wd_cnt_reg <= 32'h0000_0000;
		else if (cmd_poll || cmd_commit || !prm_reg.wd_en)
			wd_cnt_reg <= 32'h0000_0000;
		else if (!wd_expired)
			wd_cnt_reg <= wd_cnt_reg + 32'h0000_0001;
	end

	// *****************************************
	// protocol state machine
	// *****************************************
	fbs_pkg::fbs_state_t state_reg;
	fbs_pkg::fbs_state_t state_next;
	logic mod_to;

	assign mod_to     = pins_reg.mod_timeout || pins_reg.mod_fault;
	assign soft_reset = (state_reg == fbs_pkg::FBS_DATA_EX) && mod_to &&
		(prm_reg.react == fbs_pkg::FBS_REACT_RESET);

	// next state from commit, watchdog and module timeout reaction
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			fbs_pkg::FBS_WAIT_PRM:
				if (prm_valid_reg && addr_ok)
					state_next = fbs_pkg::FBS_DATA_EX;
			fbs_pkg::FBS_DATA_EX:
				if (soft_reset)
					state_next = fbs_pkg::FBS_WAIT_PRM;
				else if (prm_reg.wd_en && wd_expired)
					state_next = fbs_pkg::FBS_SAFE;
				else if (!addr_ok)
					state_next = fbs_pkg::FBS_WAIT_PRM;
			fbs_pkg::FBS_SAFE:
				// master comes back: resume with the settings in force
				if (cmd_poll || cmd_commit)
					state_next = fbs_pkg::FBS_DATA_EX;
			default:
				state_next = fbs_pkg::FBS_WAIT_PRM;
		endcase
	end

	// state register
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			state_reg <= fbs_pkg::FBS_WAIT_PRM;
		else
			state_reg <= state_next;
	end

	// *****************************************
	// output path: sync hold and rack drive
	// *****************************************
	logic [16:0] out_new_reg;   // latest master word, bit 16 = analog
	logic [16:0] out_app_reg;   // word applied to the rack
	logic        sync_reg;      // outputs held by sync

	// master writes land here first; the hold decides when they apply
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			out_new_reg <= 17'h0_0000;
		else if (wr_out)
			out_new_reg <= wdata_reg[16:0];
	end

	// sync freezes, each further sync or unsync applies the newest word
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sync_reg    <= 1'b0;
			out_app_reg <= 17'h0_0000;
		end
		else
		begin
			if (cmd_sync)
				sync_reg <= 1'b1;
			else if (cmd_unsync)
				sync_reg <= 1'b0;
			if (cmd_sync && !sync_reg)
				out_app_reg <= out_app_reg;
			else if (cmd_sync || cmd_unsync || (!sync_reg && wr_out))
				out_app_reg <= cmd_sync || cmd_unsync ?
					out_new_reg : wdata_reg[16:0];
		end
	end

	// output disable reaction keeps exchanging but zeroes the rack
	logic kill_out;
	assign kill_out = (state_reg == fbs_pkg::FBS_DATA_EX) && mod_to &&
		(prm_reg.react == fbs_pkg::FBS_REACT_DISABLE);

	// rack outputs: zero outside exchange, plain reaction leaves them
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bp_out         <= 16'h0000;
			output_disable <= 1'b0;
			safety_state   <= 1'b0;
		end
		else
		begin
			output_disable <= kill_out;
			safety_state   <= (state_next == fbs_pkg::FBS_SAFE);
			if (kill_out || state_reg != fbs_pkg::FBS_DATA_EX)
				bp_out <= 16'h0000;
			else
				bp_out <= order(out_app_reg[15:0], out_app_reg[16],
					prm_reg.little);
		end
	end

	// *****************************************
	// input path: freeze latch
	// *****************************************
	logic [16:0] in_frz_reg;   // latched input word, bit 16 = analog
	logic        freeze_reg;   // inputs frozen
	logic [16:0] in_now;

	assign in_now = freeze_reg ? in_frz_reg :
		{pins_reg.in_analog, pins_reg.in_data};

	// each freeze takes a new snapshot, unfreeze returns to live data
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			freeze_reg <= 1'b0;
			in_frz_reg <= 17'h0_0000;
		end
		else if (cmd_freeze)
		begin
			freeze_reg <= 1'b1;
			in_frz_reg <= {pins_reg.in_analog, pins_reg.in_data};
		end
		else if (cmd_unfreeze)
			freeze_reg <= 1'b0;
	end

	// *****************************************
	// transfer length check
	// *****************************************
	logic [15:0] len_reg;     // in bytes [7:0], out bytes [15:8]
	logic        len_err_reg; // requested length beyond the limit

	// lengths come with each commit; oversize requests are clamped
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			len_reg     <= 16'h0000;
			len_err_reg <= 1'b0;
		end
		else if (cmd_commit)
		begin
			len_err_reg <= (wdata_reg[23:16] > `FBS_MAX_BYTES) ||
				(wdata_reg[31:24] > `FBS_MAX_BYTES);
			len_reg[7:0] <= (wdata_reg[23:16] > `FBS_MAX_BYTES) ?
				`FBS_MAX_BYTES : wdata_reg[23:16];
			len_reg[15:8] <= (wdata_reg[31:24] > `FBS_MAX_BYTES) ?
				`FBS_MAX_BYTES : wdata_reg[31:24];
		end
	end

	// *****************************************
	// diagnostics
	// *****************************************
	logic [15:0] diag_word;
	logic        diag_on;
	assign diag_on = prm_reg.diag_en || prm_reg.ext;

	// slot, code and channel each appear only when their own enable is set
	always_comb
	begin
		diag_word = 16'h0000;
		if (diag_on && pins_reg.mod_fault)
		begin
			diag_word[15] = 1'b1;
			if (prm_reg.ident_en)
				diag_word[3:0] = pins_reg.fault_slot;
			if (prm_reg.modst_en)
				diag_word[7:4] = pins_reg.fault_code;
			if (prm_reg.chan_en)
				diag_word[10:8] = pins_reg.fault_chan;
		end
		if (diag_on && pins_reg.mod_timeout)
			diag_word[14] = 1'b1;
	end

	// *****************************************
	// axi4-lite read channel
	// *****************************************
	logic [31:0] status_word;
	assign status_word = {16'h0000, 1'b0, prm_reg.ext,
		prm_reg.ext ? 4'h0 : 4'hF,
		len_err_reg, addr_ok, prm_valid_reg, sync_reg,
		freeze_reg, wd_expired, output_disable, safety_state,
		state_reg};

	// answer one cycle after the address is taken
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `FBS_RESP_OK;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `FBS_RESP_OK;
			if (reg_slot(s_axi_araddr) == 4'h0)
				s_axi_rdata <= stage_reg;
			else if (reg_slot(s_axi_araddr) == 4'h2)
				s_axi_rdata <= {15'h0000, out_new_reg};
			else if (reg_slot(s_axi_araddr) == 4'h3)
				s_axi_rdata <= {15'h0000, in_now[16],
					order(in_now[15:0], in_now[16], prm_reg.little)};
			else if (reg_slot(s_axi_araddr) == 4'h4)
				s_axi_rdata <= status_word;
			else if (reg_slot(s_axi_araddr) == 4'h5)
				s_axi_rdata <= {16'h0000, diag_word};
			else if (reg_slot(s_axi_araddr) == 4'h6)
				s_axi_rdata <= {8'h00, `FBS_EXT_STATUS};
			else if (reg_slot(s_axi_araddr) == 4'h7)
				s_axi_rdata <= {16'h0000, len_reg};
			else if (reg_slot(s_axi_araddr) == 4'h8)
				s_axi_rdata <= {8'h00, prm_reg};
			else
			begin
				// command word is write-only; unmapped reads fail too
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `FBS_RESP_ERR;
			end
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

`default_nettype wire

// ===== fbs_cfg.svh
// fbs_cfg.svh: offsets, field positions, reset values and timing counts
// of the fieldbus slave parameter control block; definitions only.
`ifndef FBS_CFG_SVH
`define FBS_CFG_SVH

// register byte offsets on the AXI4-Lite slave
`define FBS_OFS_STAGE   8'h00
`define FBS_OFS_CMD     8'h04
`define FBS_OFS_OUT     8'h08
`define FBS_OFS_IN      8'h0C
`define FBS_OFS_STATUS  8'h10
`define FBS_OFS_DIAG    8'h14
`define FBS_OFS_EXTSTAT 8'h18
`define FBS_OFS_LEN     8'h1C
`define FBS_OFS_ACTIVE  8'h20

// staging word field positions
`define FBS_B_WD      0
`define FBS_B_IDDIAG  1
`define FBS_B_MODST   2
`define FBS_B_CHDIAG  3
`define FBS_B_DIAGEN  4
`define FBS_B_LITTLE  5
`define FBS_B_REACT   6
`define FBS_B_EXT     8
`define FBS_B_ADDR    9
`define FBS_B_GROUP   16

// command word field positions (write-only pulses)
`define FBS_C_COMMIT  0
`define FBS_C_SYNC    1
`define FBS_C_UNSYNC  2
`define FBS_C_FREEZE  3
`define FBS_C_UNFRZ   4
`define FBS_C_POLL    5
`define FBS_C_GROUP   8

// reset values: watchdog on, diagnostics on, big-endian, station 3
`define FBS_STAGE_RST 32'h0001_0611
`define FBS_EXT_STATUS 24'h00_0000
`define FBS_ADDR_MIN  7'h02
`define FBS_ADDR_MAX  7'h7D
`define FBS_MAX_BYTES 8'hF4

// axi responses
`define FBS_RESP_OK   2'h0
`define FBS_RESP_ERR  2'h2

// response monitoring time and clock rate
`define FBS_WD_TIME_US 100000
`define FBS_CLK_MHZ    50
`define FBS_WD_CYCLES  (`FBS_WD_TIME_US * `FBS_CLK_MHZ)

`endif

// ===== fbs_pkg.sv
// fbs_pkg.sv: types of the fieldbus slave parameter control block.
// assumes fbs_cfg.svh sits in the include path.
`default_nettype none
package fbs_pkg;

	// slave protocol state
	typedef enum logic [1:0] {
		FBS_WAIT_PRM,
		FBS_DATA_EX,
		FBS_SAFE
	} fbs_state_t;

	// reaction to a backplane module timeout
	typedef enum logic [1:0] {
		FBS_REACT_RESET,
		FBS_REACT_DISABLE,
		FBS_REACT_PLAIN,
		FBS_REACT_SPARE
	} fbs_react_t;

	// applied parameter set
	typedef struct packed {
		logic [7:0] group;
		logic [6:0] addr;
		logic       ext;
		fbs_react_t react;
		logic       little;
		logic       diag_en;
		logic       chan_en;
		logic       modst_en;
		logic       ident_en;
		logic       wd_en;
	} fbs_param_t;

	// pins that come from outside the clock domain
	typedef struct packed {
		logic [6:0]  addr_sw;
		logic [15:0] in_data;
		logic        in_analog;
		logic        mod_timeout;
		logic        mod_fault;
		logic [3:0]  fault_slot;
		logic [2:0]  fault_chan;
		logic [3:0]  fault_code;
	} fbs_pins_t;

endpackage
`default_nettype wire

// ===== fbs_ctrl_props.sv
// fbs_ctrl_props.sv: port checker of fbs_ctrl, bound after the module.
// assumes one clock domain and the active-low asynchronous reset.
`include "fbs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module fbs_ctrl_props #(
	parameter int unsigned WD_CYCLES = 50
) (
	input wire logic        core_clk,
	input wire logic        rstn,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [15:0] bp_out,
	input wire logic        output_disable,
	input wire logic        safety_state
);
	// ***********************************
	// one domain: clock and reset shared
	// ***********************************
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);

	// a taken response is gone the next cycle: one write at a time
	property p_bdone;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_bdone: assert property (p_bdone) else $error("write response lingers");
	// nothing new is taken while a response waits
	property p_awblock;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_awblock: assert property (p_awblock) else $error("write taken early");
	property p_rdone;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_rdone: assert property (p_rdone) else $error("read data lingers");
	property p_arblock;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_arblock: assert property (p_arblock) else $error("read taken early");
	// outputs go low one cycle after the disable at the latest
	property p_disz;
		output_disable [*2] |-> bp_out == 16'h0000;
	endproperty
	a_disz: assert property (p_disz) else $error("outputs live while disabled");
	property p_safez;
		safety_state [*2] |-> bp_out == 16'h0000;
	endproperty
	a_safez: assert property (p_safez) else $error("outputs live in safety");
	// the fixed status bytes read back as zero, never as an error
	property p_extstat;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `FBS_OFS_EXTSTAT |=>
			s_axi_rvalid && s_axi_rdata == {8'h00, `FBS_EXT_STATUS} && s_axi_rresp == `FBS_RESP_OK;
	endproperty
	a_extstat: assert property (p_extstat) else $error("fixed status wrong");
	property p_bresp;
		s_axi_bvalid |-> s_axi_bresp == `FBS_RESP_OK || s_axi_bresp == `FBS_RESP_ERR;
	endproperty
	a_bresp: assert property (p_bresp) else $error("write response code odd");
endmodule
bind fbs_ctrl fbs_ctrl_props #(.WD_CYCLES(WD_CYCLES)) fbs_ctrl_props_i (
	.core_clk(core_clk), .rstn(rstn), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .bp_out(bp_out), .output_disable(output_disable),
	.safety_state(safety_state));
`default_nettype wire

// ===== fbs_rack.sv
// fbs_rack.sv: behavioural rack of i/o modules facing fbs_ctrl.
// assumes the bench calls its tasks just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module fbs_rack (
	input  wire logic           core_clk,
	input  wire logic [15:0]    bp_out,
	input  wire logic           output_disable,
	output var fbs_pkg::fbs_pins_t pins
);
	logic [15:0] img_reg; // outputs as the modules see them

	// switch set to the station the master configures
	initial pins = '{addr_sw: 7'h03, default: '0};

	// a disabled rack shows all outputs low
	always_ff @(posedge core_clk)
		img_reg <= output_disable ? 16'h0000 : bp_out;

	// plugged modules are digital or analog only, fixed addresses
	task set_in(input logic [15:0] d, input logic an);
		pins.in_data <= d;
		pins.in_analog <= an;
	endtask

	// a module fails or returns; slot, channel and code describe it
	task set_fault(input logic f, input logic [3:0] s, input logic [2:0] c, input logic [3:0] e);
		pins.mod_fault <= f;
		pins.fault_slot <= s;
		pins.fault_chan <= c;
		pins.fault_code <= e;
	endtask
endmodule
`default_nettype wire

// ===== fbs_ctrl_tb.sv
// fbs_ctrl_tb.sv: self-checking bench of fbs_ctrl beside a rack model.
// assumes fbs_cfg.svh in the include path and one 50 MHz clock.
`include "fbs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module fbs_ctrl_tb;
	localparam int unsigned WD = 50; // short watchdog keeps the run brief
	logic        core_clk = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, output_disable, safety_state;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] bp_out;
	fbs_pkg::fbs_pins_t pins;
	int          n_fail = 0;
	int          comparisons = 0;
	int          cycles = 0;

	always #10 core_clk = ~core_clk;

	// hang guard: the whole sequence needs about 600 cycles
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_fail++;
			results();
		end
	end

	fbs_ctrl #(.WD_CYCLES(WD)) fbs_ctrl_i (.core_clk(core_clk), .rstn(rstn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pins(pins), .bp_out(bp_out), .output_disable(output_disable),
		.safety_state(safety_state));
	fbs_rack fbs_rack_i (.core_clk(core_clk), .bp_out(bp_out),
		.output_disable(output_disable), .pins(pins));

	task cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// address and data offered together, each released when taken
	task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = `FBS_RESP_OK);
		@(posedge core_clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= v;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask

	// masked read compare
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] er = `FBS_RESP_OK);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		rready <= 1'b0;
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		chk("rdata", e, rdata & m);
	endtask

	// staging word: group 1, watchdog and extended variant added by or
	function automatic logic [31:0] stg(input logic [6:0] a, input logic [1:0] rc,
		input logic lt, input logic [3:0] dg);
		return {8'h01, a, 1'b0, rc, lt, dg, 1'b0};
	endfunction

	task cm(input logic [31:0] s);
		wr(`FBS_OFS_STAGE, s);
		wr(`FBS_OFS_CMD, 32'h0404_0001);
		cyc(3);
	endtask

	task ob(input logic [31:0] v, input logic [15:0] e);
		wr(`FBS_OFS_OUT, v);
		cyc(2);
		chk("bp_out", {16'h0, e}, {16'h0, bp_out});
	endtask

	task results;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ***********************************
	// main sequence
	// ***********************************
	initial
	begin
		cyc(12);
		rstn <= 1'b1;
		rd(`FBS_OFS_STAGE, 32'hFFFF_FFFF, `FBS_STAGE_RST);
		rd(`FBS_OFS_EXTSTAT, 32'hFFFF_FFFF, 32'h0);
		wr(`FBS_OFS_IN, 32'h1, `FBS_RESP_ERR);
		rd(8'h24, 32'hFFFF_FFFF, 32'h0, `FBS_RESP_ERR);
		$display("reset test done");
		wr(`FBS_OFS_STAGE, stg(7'h03, 2'h2, 1'b0, 4'hF));
		wr(`FBS_OFS_CMD, 32'hF5F4_0001);
		cyc(3);
		rd(`FBS_OFS_LEN, 32'hFFFF, 32'hF4F4);
		rd(`FBS_OFS_STATUS, 32'h7F83, 32'h3F81);
		cm(stg(7'h04, 2'h2, 1'b0, 4'hF));
		rd(`FBS_OFS_STATUS, 32'h103, 32'h0);
		$display("address test done");
		cm(stg(7'h03, 2'h2, 1'b0, 4'hF));
		ob(32'h0001_1234, 16'h1234);
		wr(`FBS_OFS_STAGE, stg(7'h03, 2'h2, 1'b1, 4'hF));
		ob(32'h0001_5678, 16'h5678);
		cm(stg(7'h03, 2'h2, 1'b1, 4'hF));
		ob(32'h0001_1234, 16'h3412);
		ob(32'h0000_1234, 16'h1234);
		fbs_rack_i.set_in(16'hABCD, 1'b1);
		cyc(4);
		rd(`FBS_OFS_IN, 32'h1FFFF, 32'h1CDAB);
		$display("byte order test done");
		wr(`FBS_OFS_CMD, 32'h0000_0102);
		ob(32'h0000_00AA, 16'h1234);
		wr(`FBS_OFS_CMD, 32'h0000_0104);
		cyc(2);
		chk("bp_out", 32'h00AA, {16'h0, bp_out});
		wr(`FBS_OFS_CMD, 32'h0000_0202);
		ob(32'h0000_0055, 16'h0055);
		fbs_rack_i.set_in(16'h0011, 1'b0);
		cyc(4);
		wr(`FBS_OFS_CMD, 32'h0000_0108);
		fbs_rack_i.set_in(16'h0022, 1'b0);
		cyc(4);
		rd(`FBS_OFS_IN, 32'h1FFFF, 32'h0011);
		wr(`FBS_OFS_CMD, 32'h0000_0110);
		cyc(4);
		rd(`FBS_OFS_IN, 32'h1FFFF, 32'h0022);
		$display("sync and freeze test done");
		fbs_rack_i.set_fault(1'b1, 4'h5, 3'h3, 4'h9);
		cyc(4);
		rd(`FBS_OFS_DIAG, 32'h87FF, 32'h8395);
		rd(`FBS_OFS_STATUS, 32'h3, 32'h1);
		cm(stg(7'h03, 2'h2, 1'b1, 4'b1001));
		rd(`FBS_OFS_DIAG, 32'h07FF, 32'h0005);
		cm(stg(7'h03, 2'h2, 1'b1, 4'b0111));
		rd(`FBS_OFS_DIAG, 32'hFFFF, 32'h0);
		cm(stg(7'h03, 2'h1, 1'b1, 4'hF));
		chk("output_disable", 32'h1, {31'h0, output_disable});
		chk("bp_out", 32'h0, {16'h0, bp_out});
		rd(`FBS_OFS_STATUS, 32'h3, 32'h1);
		cm(stg(7'h03, 2'h0, 1'b1, 4'hF));
		rd(`FBS_OFS_STATUS, 32'h83, 32'h0);
		fbs_rack_i.set_fault(1'b0, 4'h0, 3'h0, 4'h0);
		cyc(4);
		cm(stg(7'h03, 2'h2, 1'b0, 4'hF));
		rd(`FBS_OFS_STATUS, 32'h3, 32'h1);
		$display("module fault test done");
		cm(stg(7'h03, 2'h2, 1'b0, 4'hF) | 32'h100);
		rd(`FBS_OFS_STATUS, 32'h7C00, 32'h4000);
		cyc(WD * 3);
		chk("safety_state", 32'h0, {31'h0, safety_state});
		cm(stg(7'h03, 2'h2, 1'b0, 4'hF) | 32'h101);
		wr(`FBS_OFS_CMD, 32'h0000_0020);
		cyc(WD * 3);
		chk("safety_state", 32'h1, {31'h0, safety_state});
		chk("bp_out", 32'h0, {16'h0, bp_out});
		wr(`FBS_OFS_CMD, 32'h0000_0020);
		cyc(3);
		chk("safety_state", 32'h0, {31'h0, safety_state});
		$display("variant and watchdog test done");
		results();
	end
endmodule
`default_nettype wire
